// ---- src/fpet_pkg.sv ----
// constants, register map and state codes of the flash program/erase timing controller
// What this block does
// RL1: wait at least 1 us after write enable before the next step
// RL2: wait at least 50 us after program setup before the program pulse
// RL3: program pulse lasts 30 us for writes 1-6, 200 us later, 10 us additional
// RL4: program pulse stays inside 28-32, 198-202 or 8-12 us
// RL5: program pulse repetitions limited, never above 1000
// RL6: wait at least 5 us after pulse clear before setup clear
// RL7: wait at least 5 us after setup clear before program verify
// RL8: wait at least 4 us after program verify before the dummy write
// RL9: wait at least 2 us after the dummy write before the verify read
// RL10: wait at least 2 us after verify clear before next pulse or exit
// RL11: wait at least 100 us after write enable clear before normal use
// RL12: wait at least 100 us after erase setup before the erase pulse
// RL13: erase pulse lasts 10 to 100 ms, at most 120 pulses per block
// RL14: wait at least 10 us after erase pulse clear before setup clear
// RL15: wait at least 10 us after erase setup clear before erase verify
// RL16: erase verify: 20 us before dummy write, then 2 us before read
// RL17: wait at least 4 us after erase verify clear before next step
// RL18: program 128-byte units, counted time covers only pulse intervals
// RL19: erase whole blocks, counted time covers only erase pulse intervals
// RL20: program order: enable, setup, pulse, clears, verify, repeat or disable
// RL21: erase order: enable, setup, pulse, clears, verify, repeat or disable
package fpet_pkg;
	localparam int unsigned CLK_MHZ = 10; // clock rate in MHz
	localparam int unsigned CYC_W   = 17; // width of every wait count except EZ_HI_CYC
	// program waits in microseconds
	localparam int unsigned T_WEN_US    = 1;
	localparam int unsigned T_PSETUP_US = 50;
	localparam int unsigned T_Z1_US     = 30;
	localparam int unsigned T_Z2_US     = 200;
	localparam int unsigned T_Z3_US     = 10;
	localparam int unsigned T_Z1_LO_US  = 28;
	localparam int unsigned T_Z1_HI_US  = 32;
	localparam int unsigned T_Z2_LO_US  = 198;
	localparam int unsigned T_Z2_HI_US  = 202;
	localparam int unsigned T_Z3_LO_US  = 8;
	localparam int unsigned T_Z3_HI_US  = 12;
	localparam int unsigned T_PALPHA_US = 5;
	localparam int unsigned T_PBETA_US  = 5;
	localparam int unsigned T_PGAMMA_US = 4;
	localparam int unsigned T_PEPS_US   = 2;
	localparam int unsigned T_PETA_US   = 2;
	localparam int unsigned T_WDIS_US   = 100;
	// erase waits in microseconds and milliseconds
	localparam int unsigned T_ESETUP_US = 100;
	localparam int unsigned T_EZ_LO_MS  = 10;
	localparam int unsigned T_EZ_HI_MS  = 100;
	localparam int unsigned T_EALPHA_US = 10;
	localparam int unsigned T_EBETA_US  = 10;
	localparam int unsigned T_EGAMMA_US = 20;
	localparam int unsigned T_EEPS_US   = 2;
	localparam int unsigned T_EETA_US   = 4;
	// waits as clock counts
	localparam logic [CYC_W-1:0] WEN_CYC    = CYC_W'(T_WEN_US * CLK_MHZ);
	localparam logic [CYC_W-1:0] PSETUP_CYC = CYC_W'(T_PSETUP_US * CLK_MHZ);
	localparam logic [CYC_W-1:0] Z1_CYC     = CYC_W'(T_Z1_US * CLK_MHZ);
	localparam logic [CYC_W-1:0] Z2_CYC     = CYC_W'(T_Z2_US * CLK_MHZ);
	localparam logic [CYC_W-1:0] Z3_CYC     = CYC_W'(T_Z3_US * CLK_MHZ);
	localparam logic [CYC_W-1:0] Z1_LO_CYC  = CYC_W'(T_Z1_LO_US * CLK_MHZ);
	localparam logic [CYC_W-1:0] Z1_HI_CYC  = CYC_W'(T_Z1_HI_US * CLK_MHZ);
	localparam logic [CYC_W-1:0] Z2_LO_CYC  = CYC_W'(T_Z2_LO_US * CLK_MHZ);
	localparam logic [CYC_W-1:0] Z2_HI_CYC  = CYC_W'(T_Z2_HI_US * CLK_MHZ);
	localparam logic [CYC_W-1:0] Z3_LO_CYC  = CYC_W'(T_Z3_LO_US * CLK_MHZ);
	localparam logic [CYC_W-1:0] Z3_HI_CYC  = CYC_W'(T_Z3_HI_US * CLK_MHZ);
	localparam logic [CYC_W-1:0] PALPHA_CYC = CYC_W'(T_PALPHA_US * CLK_MHZ);
	localparam logic [CYC_W-1:0] PBETA_CYC  = CYC_W'(T_PBETA_US * CLK_MHZ);
	localparam logic [CYC_W-1:0] PGAMMA_CYC = CYC_W'(T_PGAMMA_US * CLK_MHZ);
	localparam logic [CYC_W-1:0] PEPS_CYC   = CYC_W'(T_PEPS_US * CLK_MHZ);
	localparam logic [CYC_W-1:0] PETA_CYC   = CYC_W'(T_PETA_US * CLK_MHZ);
	localparam logic [CYC_W-1:0] WDIS_CYC   = CYC_W'(T_WDIS_US * CLK_MHZ);
	localparam logic [CYC_W-1:0] ESETUP_CYC = CYC_W'(T_ESETUP_US * CLK_MHZ);
	localparam logic [CYC_W-1:0] EZ_LO_CYC  = CYC_W'(T_EZ_LO_MS * 1000 * CLK_MHZ);
	localparam logic [CYC_W-1:0] EALPHA_CYC = CYC_W'(T_EALPHA_US * CLK_MHZ);
	localparam logic [CYC_W-1:0] EBETA_CYC  = CYC_W'(T_EBETA_US * CLK_MHZ);
	localparam logic [CYC_W-1:0] EGAMMA_CYC = CYC_W'(T_EGAMMA_US * CLK_MHZ);
	localparam logic [CYC_W-1:0] EEPS_CYC   = CYC_W'(T_EEPS_US * CLK_MHZ);
	localparam logic [CYC_W-1:0] EETA_CYC   = CYC_W'(T_EETA_US * CLK_MHZ);
	localparam int unsigned      EZ_HI_CYC  = T_EZ_HI_MS * 1000 * CLK_MHZ;
	// pulse limits and unit sizes
	localparam logic [9:0] PROG_MAX    = 10'h3E8; // 1000 pulses
	localparam logic [9:0] ERASE_MAX   = 10'h078; // 120 pulses
	localparam logic [9:0] EARLY_WRITES = 10'h006;
	localparam int unsigned UNIT_BYTES = 128;
	// register map, byte addresses
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_LIMIT  = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_PTIME  = 8'h0C;
	// field positions
	localparam int unsigned CTRL_PROG  = 0;
	localparam int unsigned CTRL_ERASE = 1;
	localparam int unsigned CTRL_ADDL  = 2;
	localparam int unsigned ST_BUSY    = 0;
	localparam int unsigned ST_DONE    = 1;
	localparam int unsigned ST_FAIL    = 2;
	localparam int unsigned ST_ERASE   = 3;
	localparam int unsigned ST_CNT_LSB = 16;
	localparam int unsigned LIM_E_LSB  = 16;
	// reset values and response codes
	localparam logic [31:0] LIMIT_RST = 32'h0078_03E8;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	// sequencer states, Gray coded along the usual path
	typedef enum logic [3:0] {
		S_IDLE  = 4'h0,
		S_WEN   = 4'h1,
		S_SETUP = 4'h3,
		S_PULSE = 4'h2,
		S_PCLR  = 4'h6,
		S_SCLR  = 4'h7,
		S_VSET  = 4'h5,
		S_DWR   = 4'h4,
		S_VRD   = 4'hC,
		S_WDIS  = 4'hD
	} fpet_state_type;
endpackage

// ---- src/fpet_wait_timer.sv ----
// countdown timer that pulses once when a loaded wait has elapsed
`timescale 1ns/1ps
`default_nettype none
module fpet_wait_timer #(
	parameter int unsigned W = 17
) (
	input  wire logic         i_clk,
	input  wire logic         i_sys_rst,
	input  wire logic         i_load,
	input  wire logic [W-1:0] i_cycles,
	output var  logic         o_done
);
	logic [W-1:0] cnt_ff;
	logic         run_ff;
	logic         done_ff;

	// load restarts the count; done rises N edges after the load edge
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			cnt_ff <= '0;
			run_ff <= 1'b0;
			done_ff <= 1'b0;
		end else if (i_load) begin
			cnt_ff <= i_cycles;
			run_ff <= 1'b1;
			done_ff <= 1'b0;
		end else if (run_ff) begin
			cnt_ff <= cnt_ff - W'(1);
			run_ff <= (cnt_ff != W'(1));
			done_ff <= (cnt_ff == W'(1));
		end else begin
			done_ff <= 1'b0;
		end
	end

	assign o_done = done_ff;
endmodule
`default_nettype wire

// ---- src/fpet_controller.sv ----
// flash program/erase sequencer with an AXI4-Lite command and status port
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fpet_controller #(
	parameter logic [fpet_pkg::CYC_W-1:0] P_ERASE_PULSE_CYC = fpet_pkg::EZ_LO_CYC
) (
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output var  logic        o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output var  logic        o_wready,
	output var  logic [1:0]  o_bresp,
	output var  logic        o_bvalid,
	input  wire logic        i_bready,
	input  wire logic [7:0]  i_araddr,
	input  wire logic        i_arvalid,
	output var  logic        o_arready,
	output var  logic [31:0] o_rdata,
	output var  logic [1:0]  o_rresp,
	output var  logic        o_rvalid,
	input  wire logic        i_rready,
	output var  logic        o_flash_write_enable_bit,
	output var  logic        o_program_setup_bit,
	output var  logic        o_program_pulse_bit,
	output var  logic        o_program_verify_bit,
	output var  logic        o_erase_setup_bit,
	output var  logic        o_erase_pulse_bit,
	output var  logic        o_erase_verify_bit,
	output var  logic        o_dummy_write,
	output var  logic        o_verify_read,
	input  wire logic        i_verify_pass
);
	localparam int unsigned W = fpet_pkg::CYC_W;

	fpet_pkg::fpet_state_type state_ff, nxt_state;
	logic         tmr_load, tmr_done;
	logic [W-1:0] tmr_cyc;
	logic         erase_ff, addl_ff, done_ff, fail_ff;
	logic         start_prog_ff, start_erase_ff;
	logic [9:0]   cnt_ff, lim;
	logic [31:0]  limit_ff, ptime_ff, ctrl_ff;
	logic         vpass_m_ff, vpass_s_ff;
	logic         aw_got_ff, w_got_ff, wr_fire;
	logic         nxt_aw_got, nxt_w_got, nxt_bvalid;
	logic [7:0]   awaddr_ff;
	logic [31:0]  wdata_ff, wmask, rd_word;
	logic [3:0]   wstrb_ff;
	logic         rd_hit, wr_hit;

	// two flops before the verify result is looked at
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			vpass_m_ff <= 1'b0;
			vpass_s_ff <= 1'b0;
		end else begin
			vpass_m_ff <= i_verify_pass;
			vpass_s_ff <= vpass_m_ff;
		end
	end

	// pulse limit of the running mode, clamped to the device ceiling
	always_comb begin
		if (erase_ff) begin
			lim = limit_ff[fpet_pkg::LIM_E_LSB +: 10];
			if (lim > fpet_pkg::ERASE_MAX)
				lim = fpet_pkg::ERASE_MAX; // RL13
		end else begin
			lim = limit_ff[9:0];
			if (lim > fpet_pkg::PROG_MAX)
				lim = fpet_pkg::PROG_MAX; // RL5
		end
		if (lim == 10'h000)
			lim = 10'h001; // a zero limit still runs one pulse
	end

	// sequencer: each state but S_WDIS loads the wait that the next state must pass before its exit
	always_comb begin
		nxt_state = state_ff;
		tmr_load = 1'b0;
		tmr_cyc = fpet_pkg::WEN_CYC;
		case (state_ff)
			fpet_pkg::S_IDLE: begin
				if (start_prog_ff || start_erase_ff) begin
					nxt_state = fpet_pkg::S_WEN;
					tmr_load = 1'b1;
					tmr_cyc = fpet_pkg::WEN_CYC; // RL1
				end
			end
			fpet_pkg::S_WEN: begin
				if (tmr_done) begin
					nxt_state = fpet_pkg::S_SETUP; // RL20 RL21
					tmr_load = 1'b1;
					tmr_cyc = erase_ff ? fpet_pkg::ESETUP_CYC : fpet_pkg::PSETUP_CYC; // RL2 RL12
				end
			end
			fpet_pkg::S_SETUP: begin
				if (tmr_done) begin
					nxt_state = fpet_pkg::S_PULSE;
					tmr_load = 1'b1;
					if (erase_ff)
						tmr_cyc = P_ERASE_PULSE_CYC; // RL13
					else if (addl_ff)
						tmr_cyc = fpet_pkg::Z3_CYC; // RL3
					else if (cnt_ff < fpet_pkg::EARLY_WRITES)
						tmr_cyc = fpet_pkg::Z1_CYC; // RL3
					else
						tmr_cyc = fpet_pkg::Z2_CYC; // RL3
				end
			end
			fpet_pkg::S_PULSE: begin
				if (tmr_done) begin
					nxt_state = fpet_pkg::S_PCLR;
					tmr_load = 1'b1;
					tmr_cyc = erase_ff ? fpet_pkg::EALPHA_CYC : fpet_pkg::PALPHA_CYC; // RL6 RL14
				end
			end
			fpet_pkg::S_PCLR: begin
				if (tmr_done) begin
					nxt_state = fpet_pkg::S_SCLR;
					tmr_load = 1'b1;
					tmr_cyc = erase_ff ? fpet_pkg::EBETA_CYC : fpet_pkg::PBETA_CYC; // RL7 RL15
				end
			end
			fpet_pkg::S_SCLR: begin
				if (tmr_done) begin
					nxt_state = fpet_pkg::S_VSET;
					tmr_load = 1'b1;
					tmr_cyc = erase_ff ? fpet_pkg::EGAMMA_CYC : fpet_pkg::PGAMMA_CYC; // RL8 RL16
				end
			end
			fpet_pkg::S_VSET: begin
				if (tmr_done) begin
					nxt_state = fpet_pkg::S_DWR;
					tmr_load = 1'b1;
					tmr_cyc = erase_ff ? fpet_pkg::EEPS_CYC : fpet_pkg::PEPS_CYC; // RL9 RL16
				end
			end
			fpet_pkg::S_DWR: begin
				if (tmr_done) begin
					nxt_state = fpet_pkg::S_VRD;
					tmr_load = 1'b1;
					tmr_cyc = erase_ff ? fpet_pkg::EETA_CYC : fpet_pkg::PETA_CYC; // RL10 RL17
				end
			end
			fpet_pkg::S_VRD: begin
				if (tmr_done) begin
					tmr_load = 1'b1;
					if (vpass_s_ff || cnt_ff >= lim) begin
						nxt_state = fpet_pkg::S_WDIS;
						tmr_cyc = fpet_pkg::WDIS_CYC; // RL11
					end else begin
						nxt_state = fpet_pkg::S_SETUP; // RL20 RL21
						tmr_cyc = erase_ff ? fpet_pkg::ESETUP_CYC : fpet_pkg::PSETUP_CYC;
					end
				end
			end
			fpet_pkg::S_WDIS: begin
				if (tmr_done)
					nxt_state = fpet_pkg::S_IDLE; // RL11
			end
			default: nxt_state = fpet_pkg::S_IDLE;
		endcase
	end

	fpet_wait_timer #(
		.W (W)
	) u_timer (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_load    (tmr_load),
		.i_cycles  (tmr_cyc),
		.o_done    (tmr_done)
	);

	// state, mode, pulse count and outcome
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state_ff <= fpet_pkg::S_IDLE;
			erase_ff <= 1'b0;
			addl_ff <= 1'b0;
			cnt_ff <= '0;
			done_ff <= 1'b0;
			fail_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			if (state_ff == fpet_pkg::S_IDLE && nxt_state == fpet_pkg::S_WEN) begin
				erase_ff <= !start_prog_ff;
				addl_ff <= ctrl_ff[fpet_pkg::CTRL_ADDL];
				cnt_ff <= '0;
				done_ff <= 1'b0;
				fail_ff <= 1'b0;
			end
			if (nxt_state == fpet_pkg::S_PULSE && state_ff != fpet_pkg::S_PULSE)
				cnt_ff <= cnt_ff + 10'h001; // RL5 RL13
			if (state_ff == fpet_pkg::S_VRD && nxt_state == fpet_pkg::S_WDIS)
				fail_ff <= !vpass_s_ff;
			if (state_ff == fpet_pkg::S_WDIS && nxt_state == fpet_pkg::S_IDLE)
				done_ff <= 1'b1;
		end
	end

	// flash mode pins follow the next state, so each comes from a flop
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_flash_write_enable_bit <= 1'b0;
			o_program_setup_bit <= 1'b0;
			o_program_pulse_bit <= 1'b0;
			o_program_verify_bit <= 1'b0;
			o_erase_setup_bit <= 1'b0;
			o_erase_pulse_bit <= 1'b0;
			o_erase_verify_bit <= 1'b0;
			o_dummy_write <= 1'b0;
			o_verify_read <= 1'b0;
		end else begin
			o_flash_write_enable_bit <= nxt_state != fpet_pkg::S_IDLE &&
				nxt_state != fpet_pkg::S_WDIS;
			o_program_setup_bit <= !erase_ff && (nxt_state == fpet_pkg::S_SETUP ||
				nxt_state == fpet_pkg::S_PULSE || nxt_state == fpet_pkg::S_PCLR);
			o_erase_setup_bit <= erase_ff && (nxt_state == fpet_pkg::S_SETUP ||
				nxt_state == fpet_pkg::S_PULSE || nxt_state == fpet_pkg::S_PCLR);
			o_program_pulse_bit <= !erase_ff && nxt_state == fpet_pkg::S_PULSE;
			o_erase_pulse_bit <= erase_ff && nxt_state == fpet_pkg::S_PULSE;
			o_program_verify_bit <= !erase_ff && (nxt_state == fpet_pkg::S_VSET ||
				nxt_state == fpet_pkg::S_DWR);
			o_erase_verify_bit <= erase_ff && (nxt_state == fpet_pkg::S_VSET ||
				nxt_state == fpet_pkg::S_DWR);
			o_dummy_write <= state_ff == fpet_pkg::S_VSET && nxt_state == fpet_pkg::S_DWR;
			o_verify_read <= state_ff == fpet_pkg::S_DWR && nxt_state == fpet_pkg::S_VRD;
		end
	end

	// counted time: only cycles with a pulse bit high are summed
	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			ptime_ff <= '0;
		else if (state_ff == fpet_pkg::S_IDLE && nxt_state == fpet_pkg::S_WEN)
			ptime_ff <= '0;
		else if ((o_program_pulse_bit || o_erase_pulse_bit) && ptime_ff != 32'hFFFF_FFFF)
			ptime_ff <= ptime_ff + 32'h0000_0001; // RL18 RL19
	end

	// write channel: address and data taken in either order, then answered
	assign wr_fire = aw_got_ff && w_got_ff;
	assign wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
	assign wr_hit = awaddr_ff == fpet_pkg::REG_CTRL || awaddr_ff == fpet_pkg::REG_LIMIT ||
		awaddr_ff == fpet_pkg::REG_STATUS || awaddr_ff == fpet_pkg::REG_PTIME;
	always_comb begin
		nxt_aw_got = aw_got_ff || (i_awvalid && o_awready);
		nxt_w_got = w_got_ff || (i_wvalid && o_wready);
		nxt_bvalid = o_bvalid && !i_bready;
		if (wr_fire) begin
			nxt_aw_got = 1'b0;
			nxt_w_got = 1'b0;
			nxt_bvalid = 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			awaddr_ff <= '0;
			wdata_ff <= '0;
			wstrb_ff <= '0;
			o_awready <= 1'b0;
			o_wready <= 1'b0;
			o_bvalid <= 1'b0;
			o_bresp <= fpet_pkg::RESP_OKAY;
		end else begin
			aw_got_ff <= nxt_aw_got;
			w_got_ff <= nxt_w_got;
			o_bvalid <= nxt_bvalid;
			o_awready <= !nxt_aw_got && !nxt_bvalid;
			o_wready <= !nxt_w_got && !nxt_bvalid;
			if (i_awvalid && o_awready)
				awaddr_ff <= i_awaddr;
			if (i_wvalid && o_wready) begin
				wdata_ff <= i_wdata;
				wstrb_ff <= i_wstrb;
			end
			if (wr_fire)
				o_bresp <= wr_hit ? fpet_pkg::RESP_OKAY : fpet_pkg::RESP_SLVERR;
		end
	end

	// own registers: control pulses start a sequence only while idle
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ctrl_ff <= '0;
			limit_ff <= fpet_pkg::LIMIT_RST;
			start_prog_ff <= 1'b0;
			start_erase_ff <= 1'b0;
		end else begin
			start_prog_ff <= 1'b0;
			start_erase_ff <= 1'b0;
			if (wr_fire && awaddr_ff == fpet_pkg::REG_CTRL && wstrb_ff[0]) begin
				ctrl_ff[fpet_pkg::CTRL_ADDL] <= wdata_ff[fpet_pkg::CTRL_ADDL];
				start_prog_ff <= wdata_ff[fpet_pkg::CTRL_PROG];
				start_erase_ff <= wdata_ff[fpet_pkg::CTRL_ERASE];
			end
			if (wr_fire && awaddr_ff == fpet_pkg::REG_LIMIT)
				limit_ff <= ((limit_ff & ~wmask) | (wdata_ff & wmask)) & 32'h03FF_03FF;
		end
	end

	// read mux over the own registers
	assign rd_hit = i_araddr == fpet_pkg::REG_CTRL || i_araddr == fpet_pkg::REG_LIMIT ||
		i_araddr == fpet_pkg::REG_STATUS || i_araddr == fpet_pkg::REG_PTIME;
	always_comb begin
		rd_word = '0;
		case (i_araddr)
			fpet_pkg::REG_CTRL: rd_word = ctrl_ff;
			fpet_pkg::REG_LIMIT: rd_word = limit_ff;
			fpet_pkg::REG_STATUS: begin
				rd_word[fpet_pkg::ST_BUSY] = state_ff != fpet_pkg::S_IDLE;
				rd_word[fpet_pkg::ST_DONE] = done_ff;
				rd_word[fpet_pkg::ST_FAIL] = fail_ff;
				rd_word[fpet_pkg::ST_ERASE] = erase_ff;
				rd_word[fpet_pkg::ST_CNT_LSB +: 10] = cnt_ff;
			end
			fpet_pkg::REG_PTIME: rd_word = ptime_ff;
			default: rd_word = '0;
		endcase
	end

	// read channel: answer on the same edge that takes the address
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b0;
			o_rdata <= '0;
			o_rresp <= fpet_pkg::RESP_OKAY;
		end else if (i_arvalid && o_arready) begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b1;
			o_rdata <= rd_word;
			o_rresp <= rd_hit ? fpet_pkg::RESP_OKAY : fpet_pkg::RESP_SLVERR;
		end else if (o_rvalid && i_rready) begin
			o_rvalid <= 1'b0;
			o_arready <= 1'b1;
		end else if (!o_rvalid) begin
			o_arready <= 1'b1;
		end
	end

	// cycles since the flash pins last changed, counting only rises of dummy write and verify read
	logic [8:0]   pins, pins_ff;
	logic [W-1:0] gap_ff;
	logic         win_ok;
	assign pins = {o_flash_write_enable_bit, o_program_setup_bit, o_program_pulse_bit,
		o_program_verify_bit, o_erase_setup_bit, o_erase_pulse_bit, o_erase_verify_bit,
		o_dummy_write, o_verify_read};
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			pins_ff <= '0;
			gap_ff <= '0;
		end else begin
			pins_ff <= pins;
			if (pins[8:2] != pins_ff[8:2] || (pins[1:0] & ~pins_ff[1:0]) != 2'h0)
				gap_ff <= W'(1);
			else if (gap_ff != {W{1'b1}})
				gap_ff <= gap_ff + W'(1);
		end
	end
	assign win_ok = addl_ff ? (gap_ff >= fpet_pkg::Z3_LO_CYC && gap_ff <= fpet_pkg::Z3_HI_CYC) :
		(cnt_ff <= fpet_pkg::EARLY_WRITES) ?
		(gap_ff >= fpet_pkg::Z1_LO_CYC && gap_ff <= fpet_pkg::Z1_HI_CYC) :
		(gap_ff >= fpet_pkg::Z2_LO_CYC && gap_ff <= fpet_pkg::Z2_HI_CYC);

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	wen_first_a: assert property ($rose(o_program_setup_bit) |-> gap_ff >= fpet_pkg::WEN_CYC) // RL1
		else $error("program setup raised too soon");
	psetup_wait_a: assert property ($rose(o_program_pulse_bit) |->
		$past(o_program_setup_bit) && gap_ff >= fpet_pkg::PSETUP_CYC) // RL2
		else $error("program pulse raised too soon after setup");
	pulse_window_a: assert property ($fell(o_program_pulse_bit) |-> win_ok) // RL4
		else $error("program pulse outside its window");
	pulse_limit_a: assert property (state_ff != fpet_pkg::S_IDLE |-> cnt_ff <= lim) // RL5
		else $error("pulse count above limit");
	setup_clear_a: assert property ($fell(o_program_setup_bit) && o_flash_write_enable_bit |->
		gap_ff >= fpet_pkg::PALPHA_CYC) // RL6
		else $error("program setup cleared too soon");
	pverify_set_a: assert property ($rose(o_program_verify_bit) |->
		gap_ff >= fpet_pkg::PBETA_CYC) // RL7
		else $error("program verify raised too soon");
	dummy_wait_a: assert property ($rose(o_dummy_write) && !erase_ff |->
		o_program_verify_bit && gap_ff >= fpet_pkg::PGAMMA_CYC ##1 !o_dummy_write) // RL8
		else $error("dummy write too soon or too long");
	read_wait_a: assert property ($rose(o_verify_read) |->
		gap_ff >= (erase_ff ? fpet_pkg::EEPS_CYC : fpet_pkg::PEPS_CYC)) // RL9
		else $error("verify read too soon");
	wdis_idle_a: assert property (state_ff == fpet_pkg::S_WDIS && tmr_done |-> // RL11
		!o_flash_write_enable_bit && gap_ff >= fpet_pkg::WDIS_CYC)
		else $error("sequence ended without recovery");
	erase_pulse_a: assert property ($fell(o_erase_pulse_bit) |->
		gap_ff >= P_ERASE_PULSE_CYC && 32'(gap_ff) <= fpet_pkg::EZ_HI_CYC) // RL13
		else $error("erase pulse length wrong");
	esetup_wait_a: assert property ($rose(o_erase_pulse_bit) |->
		o_erase_setup_bit && gap_ff >= fpet_pkg::ESETUP_CYC) // RL12
		else $error("erase pulse raised too soon");
	pulse_excl_a: assert property (!(o_program_pulse_bit && !o_program_setup_bit) &&
		!(o_erase_pulse_bit && !o_erase_setup_bit)) // RL20 RL21
		else $error("pulse without setup");

	prog_done_c: cover property (state_ff == fpet_pkg::S_WDIS && !erase_ff && !fail_ff);
	erase_done_c: cover property ($rose(done_ff) && erase_ff);
	limit_fail_c: cover property ($rose(fail_ff));
endmodule
`default_nettype wire

// ---- verif/fpet_flash_model.sv ----
// flash array stand-in: answers verify reads, measures pulse and setup times
`timescale 1ns/1ps
`default_nettype none
module fpet_flash_model (
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_we,
	input  wire logic        i_setup,
	input  wire logic        i_pulse,
	input  wire logic        i_rd,
	input  wire logic [9:0]  i_pass_after,
	output logic             o_pass,
	output logic [31:0]      o_len,
	output logic [31:0]      o_gap
);
	logic [31:0] pcnt_ff;
	logic [31:0] gcnt_ff;
	logic [9:0]  reads_ff;
	// counted time covers only cycles with the pulse bit high
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			pcnt_ff <= '0;
			o_len <= '0;
		end else if (i_pulse) begin
			pcnt_ff <= pcnt_ff + 1;
		end else if (pcnt_ff != 0) begin
			o_len <= pcnt_ff;
			pcnt_ff <= '0;
		end
	end
	// setup-to-pulse span, restarted whenever setup drops
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || !i_setup) begin
			gcnt_ff <= '0;
		end else if (i_pulse && pcnt_ff == 0) begin
			o_gap <= gcnt_ff;
			gcnt_ff <= '0;
		end else if (!i_pulse) begin
			gcnt_ff <= gcnt_ff + 1;
		end
	end
	// verify result settles on the read strobe, cleared with write enable
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || !i_we) begin
			reads_ff <= '0;
			o_pass <= 1'b0;
		end else if (i_rd) begin
			reads_ff <= reads_ff + 1;
			o_pass <= (reads_ff + 10'h001) >= i_pass_after;
		end
	end
endmodule
`default_nettype wire

// ---- verif/tb_fpet_controller.sv ----
// self-checking bench for the flash program/erase timing controller
`timescale 1ns/1ps
`default_nettype none
module tb_fpet_controller;
	logic        clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0]  awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, len, gap, rd_v;
	logic [9:0]  pass_after = 10'h001;
	logic [3:0]  wstrb = 4'hF;
	logic [1:0]  bresp, rresp, resp_v;
	logic        awready, wready, bvalid, arready, rvalid, we, program_setup_bit, pp, pv, erase_setup_bit, ep, ev, dw, vr, vp;
	int          n_fail = 0, tests_run = 0;
	// free-running 10 MHz clock
	initial forever #50 clk = ~clk;
	fpet_controller #(.P_ERASE_PULSE_CYC(17'h12C)) u_fpet_controller (.i_clk(clk),
		.i_sys_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
		.i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
		.o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
		.i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
		.o_rvalid(rvalid), .i_rready(rready), .o_flash_write_enable_bit(we),
		.o_program_setup_bit(program_setup_bit), .o_program_pulse_bit(pp), .o_program_verify_bit(pv),
		.o_erase_setup_bit(erase_setup_bit), .o_erase_pulse_bit(ep), .o_erase_verify_bit(ev),
		.o_dummy_write(dw), .o_verify_read(vr), .i_verify_pass(vp));
	fpet_flash_model u_fpet_flash_model (.i_clk(clk), .i_sys_rst(rst), .i_we(we),
		.i_setup(program_setup_bit | erase_setup_bit), .i_pulse(pp | ep), .i_rd(vr), .i_pass_after(pass_after),
		.o_pass(vp), .o_len(len), .o_gap(gap));
	// compare one value
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// AXI4-Lite write, response kept in resp_v
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		resp_v = bresp;
		bready <= 1'b0;
	endtask
	// AXI4-Lite read into rd_v and resp_v
	task rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rd_v = rdata;
		resp_v = rresp;
		rready <= 1'b0;
	endtask
	// one whole sequence, then its measured pins and registers
	task run_seq(input logic [31:0] c, lim, len_e, gap_e, st_e, pt_e, input logic [9:0] pa);
		int n;
		n = 0;
		pass_after <= pa;
		wr(fpet_pkg::REG_LIMIT, lim);
		wr(fpet_pkg::REG_CTRL, c);
		repeat (3) @(posedge clk); // enable rises one cycle after the response
		do begin
			rd(fpet_pkg::REG_STATUS);
			n++;
		end while (rd_v[fpet_pkg::ST_BUSY] !== 1'b0 && n < 20000);
		chk("status", rd_v, st_e);
		chk("pulse", len, len_e);
		chk("setup", gap, gap_e);
		chk("we_off", {31'h0, we}, 32'h0);
		rd(fpet_pkg::REG_PTIME);
		chk("ptime", rd_v, pt_e);
		$display("test done ctrl %h", c);
	endtask
	// final counts and verdict
	task close_out;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// hang guard, well beyond the expected span
	initial begin
		#(100 * 80000);
		n_fail++;
		close_out;
	end
	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd(fpet_pkg::REG_LIMIT);
		chk("limit_rst", rd_v, fpet_pkg::LIMIT_RST);
		rd(fpet_pkg::REG_STATUS);
		chk("status_rst", rd_v, 32'h0000_0000);
		rd(8'h10);
		chk("bad_rd", {28'h0, resp_v, rd_v[1:0]}, {28'h0, fpet_pkg::RESP_SLVERR, 2'h0});
		wr(8'h10, 32'h0000_0001);
		chk("bad_wr", {30'h0, resp_v}, {30'h0, fpet_pkg::RESP_SLVERR});
		// only the two low byte lanes of the limit word change
		wstrb <= 4'h3;
		wr(fpet_pkg::REG_LIMIT, 32'h0001_0005);
		wstrb <= 4'hF;
		rd(fpet_pkg::REG_LIMIT);
		chk("limit_lane", rd_v, 32'h0078_0005);
		run_seq(32'h1, 32'h0078_03E8, 32'h12D, 32'h1F5, 32'h0002_0002, 32'h25A, 10'h002);
		run_seq(32'h1, 32'h0078_03E8, 32'h7D1, 32'h1F5, 32'h0007_0002, 32'hEDF, 10'h007);
		run_seq(32'h5, 32'h0078_03E8, 32'h65, 32'h1F5, 32'h0001_0002, 32'h65, 10'h001);
		run_seq(32'h2, 32'h0002_03E8, 32'h12D, 32'h3E9, 32'h0002_000E, 32'h25A, 10'h3E7);
		close_out;
	end
endmodule
`default_nettype wire
